/* File: shared/asfp_pkg.sv */
// Constants shared by the serial frame port and its sample buffer
package asfp_pkg;
    // Register bus map (byte addresses)
    localparam int ASFP_ADDR_W = 5;
    localparam logic [4:0] ASFP_OFF_CTRL = 5'h00;
    localparam logic [4:0] ASFP_OFF_CFG = 5'h04;
    localparam logic [4:0] ASFP_OFF_STAT = 5'h08;
    localparam logic [4:0] ASFP_OFF_SAMPLE = 5'h0c;
    localparam logic [4:0] ASFP_OFF_FRAME = 5'h10;
    localparam logic [1:0] ASFP_RESP_OK = 2'h0;
    localparam logic [1:0] ASFP_RESP_ERR = 2'h2;

    // Control register fields and reset values
    localparam int ASFP_CTRL_EN = 0;
    localparam logic ASFP_CTRL_EN_RST = 1'h1;
    // Status register fields
    localparam int ASFP_STAT_CHAN = 0;
    localparam int ASFP_STAT_FRAME = 2;
    localparam int ASFP_STAT_EMPTY = 3;
    localparam int ASFP_STAT_FULL = 4;
    localparam int ASFP_STAT_UNDER = 5;

    // Serial configuration word layout, first bit received is the MSB
    localparam int ASFP_CFG_BITS = 12;
    localparam int ASFP_CFG_WRITE = 11;
    localparam int ASFP_CFG_SEQ_HI = 10;
    localparam int ASFP_CFG_ADDR_HI = 7;
    localparam int ASFP_CFG_ADDR_LO = 6;
    localparam int ASFP_CFG_SEQ_LO = 3;
    localparam int ASFP_CFG_RANGE = 1;
    localparam int ASFP_CFG_CODING = 0;
    localparam logic [11:0] ASFP_CFG_RST = 12'h001;

    // Sequencer modes, {sequencer_ctl_hi, sequencer_ctl_lo}
    localparam logic [1:0] ASFP_SEQ_CONT = 2'h2;
    localparam logic [1:0] ASFP_SEQ_RUN = 2'h3;

    // Frame timing in serial clock falling edges
    localparam int ASFP_FRAME_BITS = 16;
    localparam int ASFP_RES_BITS = 12;
    localparam int ASFP_CNT_W = 5;
    localparam logic [4:0] ASFP_CFG_LAST_EDGE = 5'h0b;
    localparam logic [4:0] ASFP_CFG_EDGES = 5'h0c;
    localparam logic [4:0] ASFP_FRAME_EDGES = 5'h10;

    // Sample buffer depth
    localparam int ASFP_FIFO_DEPTH = 16;
endpackage

/* File: logic/asfp_fifo.sv */
// Sample buffer FIFO with a registered read port
module asfp_fifo
    import asfp_pkg::*;
#(
    parameter int WIDTH = ASFP_RES_BITS,
    parameter int DEPTH = ASFP_FIFO_DEPTH
) (
    input wire logic aclk, // System clock
    input wire logic aresetn, // Synchronous reset, low active
    input wire logic ce, // Clock enable
    input wire logic in_valid, // Write side offers a word
    output logic in_ready, // Storage has room
    input wire logic [WIDTH-1:0] in_data, // Word to store
    output logic out_valid, // Read register holds a word
    input wire logic out_ready, // Reader takes the word
    output logic [WIDTH-1:0] out_data, // Oldest word, registered
    output logic full // No room left in storage
);
    localparam int AW = $clog2(DEPTH);

    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW:0] wptr_r, wptr_nxt, rptr_r, rptr_nxt;
    logic [WIDTH-1:0] out_data_r, out_data_nxt;
    logic out_valid_r, out_valid_nxt;
    logic push, load, has_word;

    // Full when pointers differ only in the wrap bit
    assign full = (wptr_r[AW] != rptr_r[AW]) &&
                  (wptr_r[AW-1:0] == rptr_r[AW-1:0]);
    assign in_ready = !full;
    assign out_valid = out_valid_r;
    assign out_data = out_data_r;

    // Refill the read register whenever it empties or is taken
    always_comb begin
        has_word = (wptr_r != rptr_r);
        push = in_valid && !full;
        load = has_word && (!out_valid_r || out_ready);
        wptr_nxt = push ? wptr_r + 1'b1 : wptr_r;
        rptr_nxt = load ? rptr_r + 1'b1 : rptr_r;
        out_data_nxt = load ? mem[rptr_r[AW-1:0]] : out_data_r;
        out_valid_nxt = load || (out_valid_r && !out_ready);
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            wptr_r <= '0;
            rptr_r <= '0;
            out_valid_r <= 1'b0;
            out_data_r <= '0;
        end else if (ce) begin
            wptr_r <= wptr_nxt;
            rptr_r <= rptr_nxt;
            out_valid_r <= out_valid_nxt;
            out_data_r <= out_data_nxt;
        end
    end

    // Storage array, no reset needed
    always_ff @(posedge aclk) begin
        if (ce && push) begin
            mem[wptr_r[AW-1:0]] <= in_data;
        end
    end
endmodule

/* File: logic/asfp_port.sv */
// Serial frame port of a four-channel converter with a register bus
//
// The AXI4-Lite register port and the address map were chosen for this implementation.

// What this block does
// - Select starts the conversion; serial clock edges step the shifting.
// - Configuration bits are captured on serial clock falling edges.
// - Select falling starts a new conversion and frames the transfer.
// - Two-bit channel address picks the converted input.
// - Address and sequencer bits set channel stepping across conversions.
// - Range bit picks one or two reference spans for all inputs.
// - Output moves to the next bit on each serial falling edge.
// - Frame is two zeros, channel address, twelve result bits MSB first.
// - Coding bit picks straight binary or twos complement result.
// - Straight binary maps lowest input to zeros, full scale to ones.
// - Twos complement flips at mid-range between ones and zeros.
// - Sixteen clocks a transfer; only first twelve bits reach configuration.
// - First bit qualifies the write of the following eleven bits.
module asfp_port
    import asfp_pkg::*;
(
    input wire logic aclk, // System clock, 100 MHz
    input wire logic aresetn, // Synchronous reset, low active
    input wire logic ce, // Clock enable, freezes all state
    input wire logic sclk, // Serial clock pin
    input wire logic cs_n, // Frame select pin, low active
    input wire logic din, // Serial configuration input pin
    output logic dout, // Serial result output
    output logic dout_oe, // Result output driven
    output logic conv_start, // Conversion start pulse to front end
    output logic [1:0] conv_chan, // Channel being converted
    output logic conv_range_2x, // Doubled input span selected
    input wire logic [4:0] s_axi_awaddr, // Write address
    input wire logic s_axi_awvalid, // Write address valid
    output logic s_axi_awready, // Write address ready
    input wire logic [31:0] s_axi_wdata, // Write data
    input wire logic [3:0] s_axi_wstrb, // Write byte strobes
    input wire logic s_axi_wvalid, // Write data valid
    output logic s_axi_wready, // Write data ready
    output logic [1:0] s_axi_bresp, // Write response
    output logic s_axi_bvalid, // Write response valid
    input wire logic s_axi_bready, // Write response ready
    input wire logic [4:0] s_axi_araddr, // Read address
    input wire logic s_axi_arvalid, // Read address valid
    output logic s_axi_arready, // Read address ready
    output logic [31:0] s_axi_rdata, // Read data
    output logic [1:0] s_axi_rresp, // Read response
    output logic s_axi_rvalid, // Read data valid
    input wire logic s_axi_rready // Read data ready
);
    // Pin synchronisers; stage one feeds stage two only
    logic sclk_s1_r, sclk_s2_r, sclk_d_r;
    logic cs_s1_r, cs_s2_r, cs_d_r;
    logic din_s1_r, din_s2_r;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            sclk_s1_r <= 1'b0;
            sclk_s2_r <= 1'b0;
            sclk_d_r <= 1'b0;
            cs_s1_r <= 1'b1;
            cs_s2_r <= 1'b1;
            cs_d_r <= 1'b1;
            din_s1_r <= 1'b0;
            din_s2_r <= 1'b0;
        end else if (ce) begin
            sclk_s1_r <= sclk;
            sclk_s2_r <= sclk_s1_r;
            sclk_d_r <= sclk_s2_r;
            cs_s1_r <= cs_n;
            cs_s2_r <= cs_s1_r;
            cs_d_r <= cs_s2_r;
            din_s1_r <= din;
            din_s2_r <= din_s1_r;
        end
    end

    // Serial frame state
    logic frame_r, frame_nxt;
    logic [ASFP_CNT_W-1:0] fall_cnt_r, fall_cnt_nxt;
    logic [ASFP_CFG_BITS-1:0] sh_r, sh_nxt, cfg_r, cfg_nxt;
    logic [ASFP_FRAME_BITS-1:0] frame_sh_r, frame_sh_nxt;
    logic [ASFP_FRAME_BITS-1:0] last_frame_r, last_frame_nxt;
    logic cfg_wr_r, cfg_wr_nxt, dout_r, dout_nxt;
    logic [1:0] chan_cur_r, chan_cur_nxt, conv_chan_r, conv_chan_nxt;
    logic conv_start_r, conv_start_nxt, under_r, under_nxt;
    logic en_r, en_nxt;
    logic start_evt, fall_evt, end_evt;
    logic [1:0] seq_mode, addr;
    logic [ASFP_RES_BITS-1:0] coded;
    logic fifo_in_valid, fifo_in_ready, fifo_out_valid, fifo_pop, fifo_full;
    logic [ASFP_RES_BITS-1:0] fifo_out_data, sample_data;
    logic under_clr;

    // Edges as seen after synchronisation
    assign start_evt = cs_d_r && !cs_s2_r && en_r;
    assign fall_evt = frame_r && sclk_d_r && !sclk_s2_r;
    assign end_evt = frame_r && cs_s2_r;
    assign seq_mode = {cfg_r[ASFP_CFG_SEQ_HI], cfg_r[ASFP_CFG_SEQ_LO]};
    assign addr = cfg_r[ASFP_CFG_ADDR_HI:ASFP_CFG_ADDR_LO];
    assign fifo_pop = start_evt;

    // Coding: straight binary passes through, twos complement flips MSB
    always_comb begin
        coded = fifo_out_valid ? fifo_out_data : '0;
        if (!cfg_r[ASFP_CFG_CODING]) begin
            coded[ASFP_RES_BITS-1] = !coded[ASFP_RES_BITS-1];
        end
    end

    // Next state of the serial side
    always_comb begin
        frame_nxt = frame_r && !cs_s2_r && en_r;
        fall_cnt_nxt = fall_cnt_r;
        sh_nxt = sh_r;
        cfg_nxt = cfg_r;
        cfg_wr_nxt = cfg_wr_r;
        frame_sh_nxt = frame_sh_r;
        last_frame_nxt = last_frame_r;
        dout_nxt = dout_r;
        chan_cur_nxt = chan_cur_r;
        conv_chan_nxt = conv_chan_r;
        conv_start_nxt = 1'b0;
        under_nxt = under_r && !under_clr;
        if (start_evt) begin
            frame_nxt = 1'b1;
            fall_cnt_nxt = '0;
            cfg_wr_nxt = 1'b0;
            conv_start_nxt = 1'b1;
            conv_chan_nxt = chan_cur_r;
            frame_sh_nxt = {2'b00, chan_cur_r, coded};
            last_frame_nxt = {2'b00, chan_cur_r, coded};
            dout_nxt = 1'b0;
            if (!fifo_out_valid) begin
                under_nxt = 1'b1;
            end
        end else if (fall_evt) begin
            // Next bit goes out on every falling edge
            frame_sh_nxt = {frame_sh_r[ASFP_FRAME_BITS-2:0], 1'b0};
            dout_nxt = frame_sh_r[ASFP_FRAME_BITS-2];
            if (fall_cnt_r < ASFP_CFG_EDGES) begin
                sh_nxt = {sh_r[ASFP_CFG_BITS-2:0], din_s2_r};
            end
            if (fall_cnt_r == ASFP_CFG_LAST_EDGE &&
                sh_r[ASFP_CFG_BITS-2]) begin
                cfg_nxt = {sh_r[ASFP_CFG_BITS-2:0], din_s2_r};
                cfg_wr_nxt = 1'b1;
            end
            if (fall_cnt_r < ASFP_FRAME_EDGES) begin
                fall_cnt_nxt = fall_cnt_r + 1'b1;
            end
        end else if (end_evt) begin
            // Sequencer step between conversions
            if (cfg_wr_r && seq_mode != ASFP_SEQ_CONT) begin
                chan_cur_nxt = (seq_mode == ASFP_SEQ_RUN) ? 2'h0 : addr;
            end else if (seq_mode[1]) begin
                chan_cur_nxt = (chan_cur_r == addr) ? 2'h0
                                                    : chan_cur_r + 1'b1;
            end else begin
                chan_cur_nxt = addr;
            end
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            frame_r <= 1'b0;
            fall_cnt_r <= '0;
            sh_r <= '0;
            cfg_r <= ASFP_CFG_RST;
            cfg_wr_r <= 1'b0;
            frame_sh_r <= '0;
            last_frame_r <= '0;
            dout_r <= 1'b0;
            chan_cur_r <= 2'h0;
            conv_chan_r <= 2'h0;
            conv_start_r <= 1'b0;
            under_r <= 1'b0;
        end else if (ce) begin
            frame_r <= frame_nxt;
            fall_cnt_r <= fall_cnt_nxt;
            sh_r <= sh_nxt;
            cfg_r <= cfg_nxt;
            cfg_wr_r <= cfg_wr_nxt;
            frame_sh_r <= frame_sh_nxt;
            last_frame_r <= last_frame_nxt;
            dout_r <= dout_nxt;
            chan_cur_r <= chan_cur_nxt;
            conv_chan_r <= conv_chan_nxt;
            conv_start_r <= conv_start_nxt;
            under_r <= under_nxt;
        end
    end

    assign dout = dout_r;
    assign dout_oe = frame_r;
    assign conv_start = conv_start_r;
    assign conv_chan = conv_chan_r;
    assign conv_range_2x = cfg_r[ASFP_CFG_RANGE];

    // Raw converter codes wait here until a frame starts
    asfp_fifo #(
        .WIDTH(ASFP_RES_BITS),
        .DEPTH(ASFP_FIFO_DEPTH)
    ) u_fifo (
        .aclk(aclk),
        .aresetn(aresetn),
        .ce(ce),
        .in_valid(fifo_in_valid),
        .in_ready(fifo_in_ready),
        .in_data(sample_data),
        .out_valid(fifo_out_valid),
        .out_ready(fifo_pop),
        .out_data(fifo_out_data),
        .full(fifo_full)
    );

    // Register bus: address and data held until both arrive
    logic aw_held_r, aw_held_nxt, w_held_r, w_held_nxt;
    logic [4:0] awaddr_r, awaddr_nxt;
    logic [31:0] wdata_r, wdata_nxt, rdata_r, rdata_nxt, rd_val;
    logic [3:0] wstrb_r, wstrb_nxt;
    logic bvalid_r, bvalid_nxt, rvalid_r, rvalid_nxt;
    logic [1:0] bresp_r, bresp_nxt, rresp_r, rresp_nxt;
    logic wr_go, wr_done, rd_hit;

    assign s_axi_awready = !aw_held_r;
    assign s_axi_wready = !w_held_r;
    assign s_axi_arready = !rvalid_r;
    assign wr_go = aw_held_r && w_held_r && !bvalid_r;
    // A sample write stalls while the buffer is full
    assign fifo_in_valid = wr_go && awaddr_r == ASFP_OFF_SAMPLE;
    // Held copy, the live bus data may already have moved on
    assign sample_data = wdata_r[ASFP_RES_BITS-1:0];
    assign wr_done = wr_go && (awaddr_r != ASFP_OFF_SAMPLE || fifo_in_ready);
    assign under_clr = wr_done && awaddr_r == ASFP_OFF_STAT &&
                       wstrb_r[0] && wdata_r[ASFP_STAT_UNDER];

    // Read mux; unused bits read zero
    always_comb begin
        rd_val = '0;
        rd_hit = 1'b1;
        case (s_axi_araddr)
            ASFP_OFF_CTRL: rd_val[ASFP_CTRL_EN] = en_r;
            ASFP_OFF_CFG: rd_val[ASFP_CFG_BITS-1:0] = cfg_r;
            ASFP_OFF_STAT: begin
                rd_val[ASFP_STAT_CHAN+1:ASFP_STAT_CHAN] = chan_cur_r;
                rd_val[ASFP_STAT_FRAME] = frame_r;
                rd_val[ASFP_STAT_EMPTY] = !fifo_out_valid;
                rd_val[ASFP_STAT_FULL] = fifo_full;
                rd_val[ASFP_STAT_UNDER] = under_r;
            end
            ASFP_OFF_SAMPLE: rd_val = '0;
            ASFP_OFF_FRAME: rd_val[ASFP_FRAME_BITS-1:0] = last_frame_r;
            default: rd_hit = 1'b0;
        endcase
    end

    // Next state of the bus slave
    always_comb begin
        aw_held_nxt = aw_held_r;
        w_held_nxt = w_held_r;
        awaddr_nxt = awaddr_r;
        wdata_nxt = wdata_r;
        wstrb_nxt = wstrb_r;
        bvalid_nxt = bvalid_r && !s_axi_bready;
        bresp_nxt = bresp_r;
        rvalid_nxt = rvalid_r && !s_axi_rready;
        rdata_nxt = rdata_r;
        rresp_nxt = rresp_r;
        en_nxt = en_r;
        if (s_axi_awvalid && !aw_held_r) begin
            aw_held_nxt = 1'b1;
            awaddr_nxt = s_axi_awaddr;
        end
        if (s_axi_wvalid && !w_held_r) begin
            w_held_nxt = 1'b1;
            wdata_nxt = s_axi_wdata;
            wstrb_nxt = s_axi_wstrb;
        end
        if (wr_done) begin
            aw_held_nxt = 1'b0;
            w_held_nxt = 1'b0;
            bvalid_nxt = 1'b1;
            bresp_nxt = ASFP_RESP_OK;
            case (awaddr_r)
                ASFP_OFF_CTRL: begin
                    if (wstrb_r[0]) begin
                        en_nxt = wdata_r[ASFP_CTRL_EN];
                    end
                end
                ASFP_OFF_CFG, ASFP_OFF_STAT, ASFP_OFF_SAMPLE,
                ASFP_OFF_FRAME: bresp_nxt = ASFP_RESP_OK;
                default: bresp_nxt = ASFP_RESP_ERR;
            endcase
        end
        if (s_axi_arvalid && !rvalid_r) begin
            rvalid_nxt = 1'b1;
            rdata_nxt = rd_val;
            rresp_nxt = rd_hit ? ASFP_RESP_OK : ASFP_RESP_ERR;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_held_r <= 1'b0;
            w_held_r <= 1'b0;
            awaddr_r <= '0;
            wdata_r <= '0;
            wstrb_r <= '0;
            bvalid_r <= 1'b0;
            bresp_r <= ASFP_RESP_OK;
            rvalid_r <= 1'b0;
            rdata_r <= '0;
            rresp_r <= ASFP_RESP_OK;
            en_r <= ASFP_CTRL_EN_RST;
        end else if (ce) begin
            aw_held_r <= aw_held_nxt;
            w_held_r <= w_held_nxt;
            awaddr_r <= awaddr_nxt;
            wdata_r <= wdata_nxt;
            wstrb_r <= wstrb_nxt;
            bvalid_r <= bvalid_nxt;
            bresp_r <= bresp_nxt;
            rvalid_r <= rvalid_nxt;
            rdata_r <= rdata_nxt;
            rresp_r <= rresp_nxt;
            en_r <= en_nxt;
        end
    end

    assign s_axi_bvalid = bvalid_r;
    assign s_axi_bresp = bresp_r;
    assign s_axi_rvalid = rvalid_r;
    assign s_axi_rdata = rdata_r;
    assign s_axi_rresp = rresp_r;

    // Checks on the frame logic and the bus write response
    default clocking @(posedge aclk); endclocking
    default disable iff (!aresetn);

    AST_OE_OFF: assert property (ce && cs_s2_r |=> !dout_oe)
        else $error("output driven with select high");
    AST_START_FRAME: assert property (ce && start_evt |=>
        dout_oe && conv_start && !dout && conv_chan == $past(chan_cur_r))
        else $error("frame start not taken");
    AST_HEAD: assert property (ce && start_evt |=>
        frame_sh_r[15:12] == {2'b00, $past(chan_cur_r)})
        else $error("frame head wrong");
    AST_SHIFT: assert property (ce && fall_evt |=>
        dout == $past(frame_sh_r[14]))
        else $error("output bit not advanced");
    AST_HOLD: assert property (ce && frame_r && !fall_evt && !start_evt
        |=> $stable(dout))
        else $error("output moved without falling edge");
    AST_CFG_QUAL: assert property (cfg_r != $past(cfg_r) |->
        $past(fall_evt && fall_cnt_r == 5'h0b && sh_r[10]))
        else $error("configuration changed without qualified 12th edge");
    AST_CFG_LATE: assert property (ce && fall_evt &&
        fall_cnt_r >= 5'h0c |=> $stable(cfg_r) && $stable(sh_r))
        else $error("late bit reached configuration");
    AST_CODING: assert property (ce && start_evt && fifo_out_valid &&
        !cfg_r[0] |=> frame_sh_r[11] == !$past(fifo_out_data[11]))
        else $error("twos complement MSB not inverted");
    AST_SEQ_WRAP: assert property (ce && end_evt && !start_evt &&
        !cfg_wr_r && seq_mode[1] && chan_cur_r == addr
        |=> chan_cur_r == 2'h0)
        else $error("sequencer did not wrap");
    AST_B_HOLD: assert property (s_axi_bvalid && !s_axi_bready
        |=> s_axi_bvalid && $stable(s_axi_bresp))
        else $error("write response dropped");
endmodule

/* File: bench/asfp_host_model.sv */
// Host-side serial master model driving the converter frame port
module asfp_host_model (
    input wire logic dout, // Result bit from the port
    input wire logic dout_oe, // Result output driven
    output logic sclk, // Serial clock, rests high between frames
    output logic cs_n, // Frame select, low active
    output logic din // Configuration bit to the port
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [15:0] rx;
    int oe_bad;

    // Idle levels at time zero
    initial begin
        sclk = 1'b1;
        cs_n = 1'b1;
        din = 1'b0;
        rx = 16'h0000;
        oe_bad = 0;
    end

    // One sixteen-clock frame; each bit is read just before the next fall
    task automatic frame(input logic [15:0] tx, input logic en);
        #3;
        cs_n = 1'b0;
        #80;
        for (int i = 15; i >= 0; i--) begin
            din = tx[i];
            #40;
            rx[i] = dout;
            if (dout_oe !== en) oe_bad++;
            sclk = 1'b0;
            #40;
            sclk = 1'b1;
        end
        #40;
        cs_n = 1'b1;
        din = ~din; // Released line must not keep a stale value
        #117; // Whole frame spans full clock periods, pins stay off the edge
        if (dout_oe !== 1'b0) oe_bad++;
    endtask
endmodule

/* File: bench/testbench.sv */
// Self-checking bench for the converter serial frame port
module testbench
    import asfp_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    logic aclk = 1'b0;
    logic aresetn = 1'b0;
    logic [4:0] awaddr = 5'h00;
    logic [4:0] araddr = 5'h00;
    logic [31:0] wdata = 32'h0;
    logic awvalid = 1'b0;
    logic wvalid = 1'b0;
    logic bready = 1'b0;
    logic arvalid = 1'b0;
    logic rready = 1'b0;
    logic awready, wready, bvalid, arready, rvalid;
    logic [1:0] bresp, rresp, conv_chan, chan_seen;
    logic [31:0] rdata;
    logic sclk, cs_n, din, dout, dout_oe, conv_start, conv_range_2x;
    int errors = 0;
    int samples_checked = 0;
    int starts = 0;

    // Free-running system clock
    initial begin
        forever #5 aclk = ~aclk;
    end

    // Conversion starts and the channel each one converts
    always_ff @(posedge aclk) begin
        if (conv_start === 1'b1) begin
            starts <= starts + 1;
            chan_seen <= conv_chan;
        end
    end

    asfp_port DUT (.aclk(aclk), .aresetn(aresetn), .ce(1'b1),
        .sclk(sclk), .cs_n(cs_n), .din(din), .dout(dout),
        .dout_oe(dout_oe), .conv_start(conv_start),
        .conv_chan(conv_chan), .conv_range_2x(conv_range_2x),
        .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
        .s_axi_awready(awready), .s_axi_wdata(wdata),
        .s_axi_wstrb(4'hf), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
        .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
        .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
        .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
        .s_axi_rvalid(rvalid), .s_axi_rready(rready));

    asfp_host_model HOST (.dout(dout), .dout_oe(dout_oe), .sclk(sclk),
        .cs_n(cs_n), .din(din));

    task automatic results();
        $display("errors=%0d samples_checked=%0d", errors, samples_checked);
        if (errors == 0 && samples_checked > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        samples_checked++;
        if (got !== exp) begin
            errors++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    // Bus write; ready is looked at before the edge that takes it
    task automatic wr(input logic [4:0] a, input logic [31:0] d);
        logic ta, tw, tb;
        logic [1:0] r;
        tb = 1'b0;
        @(posedge aclk);
        awaddr <= a;
        wdata <= d;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        for (int n = 0; n < 100 && !tb; n++) begin
            @(negedge aclk);
            ta = awvalid && awready;
            tw = wvalid && wready;
            tb = bvalid === 1'b1;
            r = bresp;
            @(posedge aclk);
            if (ta) awvalid <= 1'b0;
            if (tw) wvalid <= 1'b0;
        end
        bready <= 1'b0;
        if (!tb) errors++;
        if (!tb) results();
        chk({30'h0, r}, {30'h0, ASFP_RESP_OK});
    endtask

    // Bus read with expected data and response
    task automatic rd(input logic [4:0] a, input logic [31:0] e,
            input logic [1:0] er);
        logic ta, tr;
        logic [31:0] d;
        logic [1:0] r;
        tr = 1'b0;
        @(posedge aclk);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        for (int n = 0; n < 100 && !tr; n++) begin
            @(negedge aclk);
            ta = arvalid && arready;
            tr = rvalid === 1'b1;
            d = rdata;
            r = rresp;
            @(posedge aclk);
            if (ta) arvalid <= 1'b0;
        end
        rready <= 1'b0;
        if (!tr) errors++;
        if (!tr) results();
        chk(d, e);
        chk({30'h0, r}, {30'h0, er});
    endtask

    // Raw codes: ends of scale and both sides of mid-scale among them
    function automatic logic [11:0] code(input int i);
        return (i == 1) ? 12'hfff : (i == 3) ? 12'h7ff :
            (i == 4) ? 12'h800 : 12'(i * 32'h123);
    endfunction

    function automatic logic [11:0] cfgw(input logic [1:0] sq,
            input logic [1:0] ch, input logic rg, input logic cd);
        return {1'b1, sq[1], 2'h0, ch, 2'h0, sq[0], 1'h0, rg, cd};
    endfunction

    // Main sequence
    initial begin
        logic [11:0] c;
        logic [1:0] ch;
        repeat (10) @(posedge aclk);
        aresetn <= 1'b1;
        rd(ASFP_OFF_CTRL, 32'h1, ASFP_RESP_OK);
        rd(ASFP_OFF_CFG, 32'h001, ASFP_RESP_OK);
        rd(ASFP_OFF_STAT, 32'h08, ASFP_RESP_OK);
        rd(5'h14, 32'h0, ASFP_RESP_ERR);
        wr(ASFP_OFF_CFG, 32'hfff);
        rd(ASFP_OFF_CFG, 32'h001, ASFP_RESP_OK);
        for (int i = 0; i < 17; i++) wr(ASFP_OFF_SAMPLE, {20'h0, code(i)});
        rd(ASFP_OFF_STAT, 32'h10, ASFP_RESP_OK);
        // Fixed channel, no-write frame, then sequence 0..2 in twos coding
        for (int i = 0; i < 17; i++) begin
            c = (i == 0) ? cfgw(2'h0, 2'h2, 1'b1, 1'b1) :
                (i == 2) ? cfgw(2'h3, 2'h2, 1'b0, 1'b0) : 12'h000;
            ch = (i == 0) ? 2'h0 : (i < 3) ? 2'h2 : 2'((i - 3) % 3);
            HOST.frame({c, 4'h0}, 1'b1);
            chk({16'h0, HOST.rx}, {18'h0, ch, (i < 3) ? code(i) :
                code(i) ^ 12'h800});
            chk({30'h0, chan_seen}, {30'h0, ch});
            if (i == 0) chk({31'h0, conv_range_2x}, 32'h1);
            if (i == 1) rd(ASFP_OFF_CFG, {20'h0, cfgw(2'h0, 2'h2, 1'b1,
                1'b1)}, ASFP_RESP_OK);
        end
        chk({31'h0, conv_range_2x}, 32'h0);
        rd(ASFP_OFF_STAT, 32'h0a, ASFP_RESP_OK);
        HOST.frame(16'h0000, 1'b1);
        chk({28'h0, HOST.rx[15:12]}, 32'h2);
        // Continue mode keeps stepping toward the newly written end channel
        HOST.frame({cfgw(2'h2, 2'h1, 1'b0, 1'b1), 4'h0}, 1'b1);
        chk({16'h0, HOST.rx}, 32'h0800);
        HOST.frame(16'h0000, 1'b1);
        chk({16'h0, HOST.rx}, 32'h1000);
        rd(ASFP_OFF_FRAME, 32'h1000, ASFP_RESP_OK);
        rd(ASFP_OFF_STAT, 32'h28, ASFP_RESP_OK);
        wr(ASFP_OFF_STAT, 32'h20);
        rd(ASFP_OFF_STAT, 32'h08, ASFP_RESP_OK);
        wr(ASFP_OFF_CTRL, 32'h0);
        HOST.frame(16'h0000, 1'b0);
        rd(ASFP_OFF_CTRL, 32'h0, ASFP_RESP_OK);
        chk(starts, 32'd20);
        chk(HOST.oe_bad, 32'd0);
        results();
    end
endmodule
